// [core/sss_sequencer.sv]
// sub-sampling sync sequencer: sync select, burst timing, memory reorder
//
// Summary of operation
// - sync source selects external edge or input level crossing
// - external source: each falling edge of the trigger pin is a sync event
// - level crossing is the reset and default sync source
// - level source fires at programmed percent level on chosen slope
// - one burst per sync event, each burst starts one step later
// - sync events act only after the arm command
// - only arm and sync events sequence; other trigger events ignored
// - reading count command does nothing; count and interval set directly
// - effective interval accepted down to 10 ns
// - real conversions are at least 20 us apart
// - no autorange; max input picks range 10 mV through 1000 V
// - level limited to 500 percent; stored samples saturate
// - subsample with memory off forces short integer output, restored later
// - subsample with memory on keeps output format
// - arm with memory on checks fifo, empty, short format; else conflict
// - fifo memory command clears stored readings
// - delay between sync event and first burst sample, reset zero
// - memory holds samples in composite waveform order
// - bursts hold N or N-1 samples, offset one interval each
// - coupling output follows ac or dc subsample command
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "sss_consts.svh"

module sss_sequencer #(
   parameter int               MEM_AW   = 12,
   parameter logic signed [15:0] SHORT_INTEGER_FORMAT_MAX = 16'sh7FFF
) (
   input  wire logic                   clock_in,
   input  wire logic                   rst_b_in,
   input  wire sss_pkg::sss_bus_req_type bus_req_in,
   output logic [31:0]                 read_data_out,
   input  wire logic                   ext_trig_in,
   input  wire logic                   level_cmp_in,
   input  wire logic [15:0]            sample_in,
   input  wire logic                   sample_valid_in,
   output logic                        convert_out,
   output logic signed [15:0]          level_pct_out,
   output logic                        slope_neg_out,
   output logic                        dc_coupled_out,
   output logic [2:0]                  range_out,
   output logic [15:0]                 sample_out,
   output logic                        sample_valid_out,
   output logic [1:0]                  out_fmt_out,
   output logic                        busy_out,
   output logic                        conflict_out
);
   localparam int MEM_DEPTH = 1 << MEM_AW;
   localparam int MIN_CYC   = `SSS_MIN_CONV_CYC;

   typedef struct packed {
      sss_pkg::sss_state_type st;
      logic [7:0]         cfg;
      logic signed [15:0] level;
      logic [31:0]        max_in;
      logic [31:0]        eff;
      logic [31:0]        delay;
      logic [15:0]        count;
      logic               ss_mode;
      logic               dc;
      logic               force_short_integer_format;
      logic               conflict;
      logic [2:0]         range;
      sss_pkg::sss_fmt_type eff_fmt;
      logic               l_sync_ext;
      logic               l_slope;
      logic               l_mem;
      logic [31:0]        l_eff;
      logic [31:0]        l_delay;
      logic [15:0]        l_count;
      logic [15:0]        nb;
      logic [15:0]        nlen;
      logic [15:0]        nfull;
      logic [15:0]        b;
      logic [15:0]        j;
      logic [15:0]        taken;
      logic [31:0]        acc;
      logic [31:0]        prod;
      logic [31:0]        tns;
      logic [31:0]        target;
      logic [31:0]        boff;
      logic [MEM_AW-1:0]  idx;
      logic [MEM_AW-1:0]  pend_idx;
      logic [MEM_AW-1:0]  rd_ptr;
      logic               pend;
      logic [MEM_AW:0]    mem_count;
      logic [9:0]         gap;
      logic               ext_s1;
      logic               ext_s2;
      logic               ext_s3;
      logic               lvl_s1;
      logic               lvl_s2;
      logic               lvl_s3;
      logic               convert;
      logic               smp_valid;
      logic [15:0]        smp;
      logic               busy;
      logic [31:0]        rdata;
   } sss_core_state_type;

   sss_core_state_type s;
   sss_core_state_type next_s;
   logic [15:0]        mem [MEM_DEPTH];
   logic               mem_we;
   logic [MEM_AW-1:0]  mem_wa;
   logic [15:0]        mem_wd;
   logic               sync_evt;
   logic               cmd_wr;
   sss_pkg::sss_cmd_type cmd;
   logic               mem_bad;

   function automatic logic [2:0] range_of(input logic [31:0] mv);
      if (mv <= `SSS_RNG0_MV) range_of = 3'h0;
      else if (mv <= `SSS_RNG1_MV) range_of = 3'h1;
      else if (mv <= `SSS_RNG2_MV) range_of = 3'h2;
      else if (mv <= `SSS_RNG3_MV) range_of = 3'h3;
      else if (mv <= `SSS_RNG4_MV) range_of = 3'h4;
      else range_of = 3'h5;
   endfunction

   assign cmd_wr = bus_req_in.wr && (bus_req_in.addr == `SSS_OFS_COMMAND);
   assign cmd    = sss_pkg::sss_cmd_type'(bus_req_in.wdata[2:0]);
   assign mem_bad = !s.cfg[`SSS_CFG_MEM_FIFO] || (s.mem_count != '0) ||
                    (s.cfg[`SSS_CFG_MFMT_LO +: 2] != 2'(sss_pkg::FMT_SHORT_INTEGER_FORMAT)) ||
                    (32'(s.count) > MEM_DEPTH);

   // ========================================================================
   // next state
   always_comb begin
      logic        push;
      logic        pop;
      logic [15:0] blen;
      logic signed [15:0] lv;
      next_s = s;
      push = 1'b0;
      pop  = 1'b0;
      blen = 16'h0000;
      lv   = $signed(bus_req_in.wdata[15:0]);
      mem_we = 1'b0;
      mem_wa = s.pend_idx;
      mem_wd = 16'h0000;
      next_s.convert   = 1'b0;
      next_s.smp_valid = 1'b0;
      next_s.rdata     = 32'h0000_0000;
      next_s.ext_s1 = ext_trig_in;
      next_s.ext_s2 = s.ext_s1;
      next_s.ext_s3 = s.ext_s2;
      next_s.lvl_s1 = level_cmp_in;
      next_s.lvl_s2 = s.lvl_s1;
      next_s.lvl_s3 = s.lvl_s2;
      if (s.gap != '1) next_s.gap = s.gap + 10'h001;
      // only arm and the selected sync source drive sequencing
      if (s.l_sync_ext) sync_evt = s.ext_s3 & ~s.ext_s2;
      else if (s.l_slope) sync_evt = ~s.lvl_s3 & s.lvl_s2;
      else sync_evt = s.lvl_s3 & ~s.lvl_s2;
      // ---------------------------------------------------- register writes
      if (bus_req_in.wr) begin
         case (bus_req_in.addr)
            `SSS_OFS_CONFIG:    next_s.cfg = bus_req_in.wdata[7:0];
            `SSS_OFS_LEVEL: begin
               if (lv > $signed(`SSS_LEVEL_MAX))
                  next_s.level = $signed(`SSS_LEVEL_MAX);
               else if (lv < -$signed(`SSS_LEVEL_MAX))
                  next_s.level = -$signed(`SSS_LEVEL_MAX);
               else
                  next_s.level = lv;
            end
            `SSS_OFS_MAX_INPUT: next_s.max_in = bus_req_in.wdata;
            `SSS_OFS_INTERVAL: begin
               if (bus_req_in.wdata < `SSS_MIN_EFF_NS)
                  next_s.eff = `SSS_MIN_EFF_NS;
               else
                  next_s.eff = bus_req_in.wdata;
            end
            `SSS_OFS_COUNT:     next_s.count = bus_req_in.wdata[15:0];
            `SSS_OFS_DELAY:     next_s.delay = bus_req_in.wdata;
            `SSS_OFS_STATUS: begin
               if (bus_req_in.wdata[`SSS_STAT_CLR_BIT])
                  next_s.conflict = 1'b0;
            end
            default: ;
         endcase
      end
      // ---------------------------------------------------- commands
      if (cmd_wr) begin
         case (cmd)
            sss_pkg::CMD_SS_AC, sss_pkg::CMD_SS_DC: begin
               next_s.ss_mode = 1'b1;
               next_s.dc      = (cmd == sss_pkg::CMD_SS_DC);
               next_s.range   = range_of(s.max_in);
               if (!s.cfg[`SSS_CFG_MEM_EN])
                  next_s.force_short_integer_format = 1'b1;
               // memory on: output format left as it stands
            end
            sss_pkg::CMD_MEM_FIFO: begin
               next_s.cfg[`SSS_CFG_MEM_EN]   = 1'b1;
               next_s.cfg[`SSS_CFG_MEM_FIFO] = 1'b1;
            end
            sss_pkg::CMD_ARM: begin
               if (s.ss_mode && (s.st == sss_pkg::ST_IDLE)) begin
                  if ((s.cfg[`SSS_CFG_MEM_EN] && mem_bad) ||
                      (s.count == 16'h0000)) begin
                     next_s.conflict = 1'b1;
                  end else begin
                     next_s.l_sync_ext = s.cfg[`SSS_CFG_SYNC_EXT];
                     next_s.l_slope    = ~s.cfg[`SSS_CFG_SLOPE_NEG];
                     next_s.l_mem      = s.cfg[`SSS_CFG_MEM_EN];
                     next_s.l_eff      = s.eff;
                     next_s.l_delay    = s.delay;
                     next_s.l_count    = s.count;
                     next_s.acc        = 32'h0000_0000;
                     next_s.nb         = 16'h0000;
                     next_s.rd_ptr     = '0;
                     next_s.st         = sss_pkg::ST_CALC_B;
                  end
               end
            end
            sss_pkg::CMD_OTHER_FUNC: begin
               next_s.ss_mode    = 1'b0;
               next_s.force_short_integer_format = 1'b0;
               next_s.st         = sss_pkg::ST_IDLE;
            end
            // count-by-readings has no meaning while sub-sampling
            sss_pkg::CMD_READ_COUNT: ;
            default: ;
         endcase
      end
      // ---------------------------------------------------- register reads
      if (bus_req_in.rd) begin
         case (bus_req_in.addr)
            `SSS_OFS_CONFIG:    next_s.rdata = {24'h00_0000, s.cfg};
            `SSS_OFS_LEVEL:     next_s.rdata = {{16{s.level[15]}}, s.level};
            `SSS_OFS_MAX_INPUT: next_s.rdata = s.max_in;
            `SSS_OFS_INTERVAL:  next_s.rdata = s.eff;
            `SSS_OFS_COUNT:     next_s.rdata = {16'h0000, s.count};
            `SSS_OFS_DELAY:     next_s.rdata = s.delay;
            `SSS_OFS_STATUS:
               next_s.rdata = {{(15 - MEM_AW){1'b0}}, s.mem_count, 6'h00,
                               s.eff_fmt, 1'b0, s.range, s.dc, s.ss_mode,
                               s.conflict, s.busy};
            `SSS_OFS_MEM_DATA: begin
               if (s.mem_count != '0) begin
                  next_s.rdata  = {16'h0000, mem[s.rd_ptr]};
                  next_s.rd_ptr = s.rd_ptr + 1'b1;
                  pop = 1'b1;
               end
            end
            `SSS_OFS_BURST_INFO: next_s.rdata = {s.nfull, s.nlen};
            `SSS_OFS_BURST_NUM:  next_s.rdata = {16'h0000, s.nb};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
      // ---------------------------------------------------- sample return
      if (sample_valid_in && s.pend) begin
         next_s.pend = 1'b0;
         if ($signed(sample_in) > SHORT_INTEGER_FORMAT_MAX)
            mem_wd = SHORT_INTEGER_FORMAT_MAX;
         else if ($signed(sample_in) < -SHORT_INTEGER_FORMAT_MAX)
            mem_wd = -SHORT_INTEGER_FORMAT_MAX;
         else
            mem_wd = sample_in;
         if (s.l_mem) begin
            mem_we = 1'b1;
            push   = 1'b1;
         end else begin
            next_s.smp       = mem_wd;
            next_s.smp_valid = 1'b1;
         end
      end
      if (cmd_wr && (cmd == sss_pkg::CMD_MEM_FIFO)) begin
         next_s.mem_count = '0;
         next_s.rd_ptr    = '0;
      end else begin
         next_s.mem_count = s.mem_count + (MEM_AW + 1)'(push) -
                            (MEM_AW + 1)'(pop);
      end
      // ---------------------------------------------------- sequencer
      unique case (s.st)
         sss_pkg::ST_IDLE: ;
         sss_pkg::ST_CALC_B: begin
            // bursts per sweep: enough that in-burst spacing meets 20 us
            next_s.acc = s.acc + s.l_eff;
            next_s.nb  = s.nb + 16'h0001;
            if (next_s.acc >= `SSS_MIN_CONV_NS) begin
               next_s.prod = 32'h0000_0000;
               next_s.nlen = 16'h0000;
               next_s.st   = sss_pkg::ST_CALC_N;
            end
         end
         sss_pkg::ST_CALC_N: begin
            next_s.prod = s.prod + {16'h0000, s.nb};
            next_s.nlen = s.nlen + 16'h0001;
            if (next_s.prod >= {16'h0000, s.l_count}) begin
               next_s.nfull = s.l_count -
                              16'(next_s.prod - {16'h0000, s.nb});
               next_s.b     = 16'h0000;
               next_s.boff  = 32'h0000_0000;
               next_s.taken = 16'h0000;
               next_s.st    = sss_pkg::ST_WAIT_SYNC;
            end
         end
         sss_pkg::ST_WAIT_SYNC: begin
            if (sync_evt) begin
               next_s.tns    = 32'h0000_0000;
               next_s.target = s.l_delay + s.boff;
               next_s.j      = 16'h0000;
               next_s.idx    = s.b[MEM_AW-1:0];
               next_s.st     = sss_pkg::ST_BURST;
            end
         end
         sss_pkg::ST_BURST: begin
            next_s.tns = s.tns + `SSS_CLK_NS;
            blen = (s.b < s.nfull) ? s.nlen : s.nlen - 16'h0001;
            if ((s.tns >= s.target) && !s.pend &&
                ({22'h00_0000, s.gap} >= `SSS_MIN_CONV_CYC)) begin
               next_s.convert  = 1'b1;
               next_s.pend     = 1'b1;
               next_s.pend_idx = s.idx;
               next_s.gap      = 10'h000;
               next_s.taken    = s.taken + 16'h0001;
               next_s.j        = s.j + 16'h0001;
               next_s.idx      = s.idx + s.nb[MEM_AW-1:0];
               next_s.target   = s.target + s.acc;
               if (s.taken + 16'h0001 == s.l_count) begin
                  next_s.st = sss_pkg::ST_IDLE;
               end else if (s.j + 16'h0001 == blen) begin
                  next_s.b    = s.b + 16'h0001;
                  next_s.boff = s.boff + s.l_eff;
                  next_s.st   = sss_pkg::ST_WAIT_SYNC;
               end
            end
         end
      endcase
      if (cmd_wr && (cmd == sss_pkg::CMD_OTHER_FUNC))
         next_s.st = sss_pkg::ST_IDLE;
      next_s.busy = (next_s.st != sss_pkg::ST_IDLE);
      next_s.eff_fmt = next_s.force_short_integer_format ? sss_pkg::FMT_SHORT_INTEGER_FORMAT :
         sss_pkg::sss_fmt_type'(next_s.cfg[`SSS_CFG_OFMT_LO +: 2]);
   end

   // ========================================================================
   // state registers
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s         <= '0;
         s.st      <= sss_pkg::ST_IDLE;
         s.cfg     <= `SSS_CFG_RST;
         s.eff     <= `SSS_MIN_EFF_NS;
         s.delay   <= `SSS_DELAY_RST;
         s.gap     <= '1;
         s.eff_fmt <= sss_pkg::FMT_DOUBLE_INTEGER_FORMAT;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge clock_in) begin
      if (mem_we) mem[mem_wa] <= mem_wd;
   end

   assign read_data_out    = s.rdata;
   assign convert_out      = s.convert;
   assign level_pct_out    = s.level;
   assign slope_neg_out    = s.cfg[`SSS_CFG_SLOPE_NEG];
   assign dc_coupled_out   = s.dc;
   assign range_out        = s.range;
   assign sample_out       = s.smp;
   assign sample_valid_out = s.smp_valid;
   assign out_fmt_out      = s.eff_fmt;
   assign busy_out         = s.busy;
   assign conflict_out     = s.conflict;

   // ========================================================================
   // checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   logic [9:0] conv_gap;
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) conv_gap <= '1;
      else if (convert_out) conv_gap <= 10'h000;
      else if (conv_gap != '1) conv_gap <= conv_gap + 10'h001;
   end

   conv_spacing_a: assert property (
      convert_out |-> conv_gap >= MIN_CYC)
      else $error("conversions closer than minimum spacing");
   conv_armed_a: assert property (
      convert_out |-> $past(s.st) == sss_pkg::ST_BURST)
      else $error("conversion while not armed");
   ext_sync_a: assert property (
      (s.st == sss_pkg::ST_WAIT_SYNC) && s.l_sync_ext && s.ext_s3 &&
      !s.ext_s2 && !cmd_wr |=> s.st == sss_pkg::ST_BURST)
      else $error("external falling edge not taken as sync");
   lvl_sync_a: assert property (
      (s.st == sss_pkg::ST_WAIT_SYNC) && !s.l_sync_ext && !cmd_wr &&
      (s.l_slope ? (!s.lvl_s3 && s.lvl_s2) : (s.lvl_s3 && !s.lvl_s2))
      |=> s.st == sss_pkg::ST_BURST)
      else $error("level crossing not taken as sync");
   arm_conflict_a: assert property (
      cmd_wr && (cmd == sss_pkg::CMD_ARM) && s.ss_mode &&
      (s.st == sss_pkg::ST_IDLE) && s.cfg[`SSS_CFG_MEM_EN] && mem_bad
      |=> conflict_out && !busy_out ##1 !convert_out [*8])
      else $error("bad memory setup did not raise conflict");
   fifo_clear_a: assert property (
      cmd_wr && (cmd == sss_pkg::CMD_MEM_FIFO) |=> s.mem_count == '0)
      else $error("fifo command left readings stored");
   force_short_integer_format_a: assert property (
      cmd_wr && (cmd == sss_pkg::CMD_SS_AC) && !s.cfg[`SSS_CFG_MEM_EN]
      |=> out_fmt_out == 2'(sss_pkg::FMT_SHORT_INTEGER_FORMAT))
      else $error("output format not forced to short integer");
   keep_fmt_a: assert property (
      cmd_wr && (cmd == sss_pkg::CMD_SS_DC) && s.cfg[`SSS_CFG_MEM_EN]
      |=> $stable(out_fmt_out))
      else $error("output format changed with memory enabled");
   range_low_a: assert property (
      cmd_wr && (cmd == sss_pkg::CMD_SS_DC) && (s.max_in <= `SSS_RNG0_MV)
      |=> range_out == 3'h0)
      else $error("smallest max input did not select lowest range");
   level_lim_a: assert property (
      (level_pct_out <= $signed(`SSS_LEVEL_MAX)) &&
      (level_pct_out >= -$signed(`SSS_LEVEL_MAX)))
      else $error("level outside five times range");
   rdcnt_ign_a: assert property (
      cmd_wr && (cmd == sss_pkg::CMD_READ_COUNT) &&
      (s.st == sss_pkg::ST_IDLE) && !bus_req_in.rd
      |=> $stable(s.st) && $stable(s.count))
      else $error("reading count command changed sequencing");
   interval_min_a: assert property (
      s.eff >= `SSS_MIN_EFF_NS)
      else $error("effective interval below minimum");

   arm_start_c: cover property (
      s.st == sss_pkg::ST_CALC_B ##[1:1000] s.st == sss_pkg::ST_WAIT_SYNC);
   burst_done_c: cover property (
      s.st == sss_pkg::ST_BURST ##1 s.st == sss_pkg::ST_WAIT_SYNC);
   sweep_end_c: cover property ($fell(busy_out));
   conflict_c: cover property ($rose(conflict_out));
endmodule

// [core/sss_consts.svh]
// constants for the sub-sampling sync sequencer: offsets, fields, resets, times
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH
// ========================================================================
// register byte offsets
`define SSS_OFS_CONFIG     8'h00
`define SSS_OFS_LEVEL      8'h04
`define SSS_OFS_MAX_INPUT  8'h08
`define SSS_OFS_INTERVAL   8'h0C
`define SSS_OFS_COUNT      8'h10
`define SSS_OFS_DELAY      8'h14
`define SSS_OFS_COMMAND    8'h18
`define SSS_OFS_STATUS     8'h1C
`define SSS_OFS_MEM_DATA   8'h20
`define SSS_OFS_BURST_INFO 8'h24
`define SSS_OFS_BURST_NUM  8'h28
// ========================================================================
// config and status field positions
`define SSS_CFG_SYNC_EXT   0
`define SSS_CFG_SLOPE_NEG  1
`define SSS_CFG_MEM_EN     2
`define SSS_CFG_MEM_FIFO   3
`define SSS_CFG_MFMT_LO    4
`define SSS_CFG_OFMT_LO    6
`define SSS_STAT_CLR_BIT   1
// ========================================================================
// reset values
`define SSS_CFG_RST        8'h40
`define SSS_DELAY_RST      32'h0000_0000
// ========================================================================
// limits and timing, times in ns
`define SSS_LEVEL_MAX      16'h01F4
`define SSS_CLK_NS         32'h0000_0028
`define SSS_MIN_CONV_NS    32'h0000_4E20
`define SSS_MIN_EFF_NS     32'h0000_000A
`define SSS_MIN_CONV_CYC   ((`SSS_MIN_CONV_NS + `SSS_CLK_NS - 32'h1) / `SSS_CLK_NS)
// ========================================================================
// range thresholds on max input, in mV
`define SSS_RNG0_MV        32'h0000_000C
`define SSS_RNG1_MV        32'h0000_0078
`define SSS_RNG2_MV        32'h0000_04B0
`define SSS_RNG3_MV        32'h0000_2EE0
`define SSS_RNG4_MV        32'h0001_D4C0
`endif

// [core/sss_pkg.sv]
// types shared by the sub-sampling sync sequencer
package sss_pkg;
   typedef enum logic [4:0] {
      ST_IDLE      = 5'b0_0001,
      ST_CALC_B    = 5'b0_0010,
      ST_CALC_N    = 5'b0_0100,
      ST_WAIT_SYNC = 5'b0_1000,
      ST_BURST     = 5'b1_0000
   } sss_state_type;

   typedef enum logic [2:0] {
      CMD_NONE       = 3'h0,
      CMD_SS_AC      = 3'h1,
      CMD_SS_DC      = 3'h2,
      CMD_MEM_FIFO   = 3'h3,
      CMD_ARM        = 3'h4,
      CMD_OTHER_FUNC = 3'h5,
      CMD_READ_COUNT = 3'h6,
      CMD_SPARE      = 3'h7
   } sss_cmd_type;

   typedef enum logic [1:0] {
      FMT_SHORT_INTEGER_FORMAT  = 2'h0,
      FMT_DOUBLE_INTEGER_FORMAT  = 2'h1,
      FMT_DOUBLE_REAL_FORMAT = 2'h2,
      FMT_ASCII = 2'h3
   } sss_fmt_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } sss_bus_req_type;
endpackage

// [sim/sss_fe_model.sv]
// partner front end: converter answers and sync sources
`timescale 1ns/1ps
module sss_fe_model (
   input  wire logic   clock_in,
   input  wire logic   conv_in,
   output logic        trig_out,
   output logic        lvl_out,
   output logic [15:0] smp_out,
   output logic        sv_out,
   output int          n_out,
   output int          gap_out
);
   int t = 0;
   int g = 0;
   int w = -1;
   initial begin
      {lvl_out, smp_out, sv_out} = '0;
      trig_out = 1'b1;
      n_out = 0;
      gap_out = 99999;
   end
   // ===================================================================
   // sync pulses locked to a period, converter alternating fast and slow
   always @(posedge clock_in) begin
      t <= (t + 1) % 4000;
      trig_out <= (t > 1);
      lvl_out <= (t < 2000);
      g <= g + 1;
      sv_out <= 1'b0;
      if (conv_in) begin
         n_out <= n_out + 1;
         if (n_out > 0 && g + 1 < gap_out) gap_out <= g + 1;
         g <= 0;
         w <= (n_out % 2) ? 20 : 1;
      end else if (w > 0) begin
         w <= w - 1;
      end else if (w == 0) begin
         sv_out <= 1'b1;
         smp_out <= n_out[15:0];
         w <= -1;
      end else begin
         smp_out <= ~smp_out;
      end
   end
endmodule

// [sim/test_subsampling_sync_sequencer.sv]
// self-checking bench for the sub-sampling sync sequencer
`timescale 1ns/1ps
`include "sss_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
$display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_subsampling_sync_sequencer;
   logic        clock_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic [31:0] rdata, d;
   logic        conv, busy, conflict, dc, trig, lvl, sv;
   logic [2:0]  rng;
   logic [1:0]  fmt;
   logic [15:0] smp;
   logic [7:0]  seed = 8'h1C;
   int          fails = 0, checks = 0, ccount, mgap, cnt, p;
   logic [15:0] lp, so, last_so;
   logic        sn, sov;
   int          nsv = 0;
   logic [31:0] thr [6] = '{`SSS_RNG0_MV, `SSS_RNG1_MV, `SSS_RNG2_MV,
      `SSS_RNG3_MV, `SSS_RNG4_MV, `SSS_RNG4_MV + 32'h1};
   sss_pkg::sss_bus_req_type req = '0;
   always #20 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      if (sov === 1'b1) begin
         nsv <= nsv + 1;
         last_so <= so;
      end
   end
   sss_sequencer i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .bus_req_in(req), .read_data_out(rdata), .ext_trig_in(trig),
      .level_cmp_in(lvl), .sample_in(smp), .sample_valid_in(sv),
      .convert_out(conv), .level_pct_out(lp), .slope_neg_out(sn),
      .dc_coupled_out(dc), .range_out(rng), .sample_out(so),
      .sample_valid_out(sov), .out_fmt_out(fmt), .busy_out(busy),
      .conflict_out(conflict));
   sss_fe_model i_fe (.clock_in(clock_in), .conv_in(conv), .trig_out(trig),
      .lvl_out(lvl), .smp_out(smp), .sv_out(sv), .n_out(ccount),
      .gap_out(mgap));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // acquisition number of memory slot q, four bursts of n1 full ones
   function automatic logic [15:0] slot(input int q, input int n);
      int nb, n1, b;
      nb = (n + 3) / 4;
      n1 = n - 4 * (nb - 1);
      b = q % 4;
      return 16'(b * (nb - 1) + ((b < n1) ? b : n1) + q / 4 + 1);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in) req <= '{a, v, 1'b1, 1'b0};
      @(posedge clock_in) req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock_in) req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock_in) req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic cmd(input sss_pkg::sss_cmd_type c);
      wr(`SSS_OFS_COMMAND, {29'h0, c});
      repeat (2) @(posedge clock_in);
      #1;
   endtask
   task automatic sweep();
      cmd(sss_pkg::CMD_ARM);
      for (p = 0; p < 60000 && busy !== 1'b0; p++) @(posedge clock_in);
      repeat (30) @(posedge clock_in);
      `CHK(busy, 1'b0)
   endtask
   task automatic results();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clock_in);
      fails++;
      results();
   end
   initial begin
      repeat (3) @(posedge clock_in);
      rst_b_in <= 1'b1;
      rd(`SSS_OFS_CONFIG);
      `CHK(d, 32'h0000_0040)
      rd(`SSS_OFS_DELAY);
      `CHK(d, 32'h0000_0000)
      wr(`SSS_OFS_INTERVAL, 32'h0000_0005);
      rd(`SSS_OFS_INTERVAL);
      `CHK(d, 32'h0000_000A)
      wr(`SSS_OFS_LEVEL, 32'h0000_0258);
      rd(`SSS_OFS_LEVEL);
      `CHK(d, 32'h0000_01F4)
      `CHK(lp, 16'h01F4)
      for (p = 0; p < 6; p++) begin
         wr(`SSS_OFS_MAX_INPUT, thr[p]);
         cmd(sss_pkg::CMD_SS_DC);
         `CHK(rng, 3'(p))
      end
      `CHK(fmt, 2'h0)
      `CHK(dc, 1'b1)
      cmd(sss_pkg::CMD_SS_AC);
      `CHK(dc, 1'b0)
      cmd(sss_pkg::CMD_OTHER_FUNC);
      `CHK(fmt, 2'h1)
      `CHK(ccount, 0)
      wr(`SSS_OFS_CONFIG, 32'h0000_0084);
      cmd(sss_pkg::CMD_SS_DC);
      wr(`SSS_OFS_COUNT, 32'h0000_0005);
      cmd(sss_pkg::CMD_ARM);
      `CHK(conflict, 1'b1)
      `CHK(busy, 1'b0)
      wr(`SSS_OFS_STATUS, 32'h0000_0002);
      rd(`SSS_OFS_STATUS);
      `CHK(d[1], 1'b0)
      $display("setup tests done");
      seed = lfsr(seed);
      cnt = 5 + seed % 8;
      wr(`SSS_OFS_CONFIG, 32'h0000_008D);
      cmd(sss_pkg::CMD_MEM_FIFO);
      cmd(sss_pkg::CMD_SS_DC);
      `CHK(fmt, 2'h2)
      wr(`SSS_OFS_INTERVAL, 32'h0000_1388);
      wr(`SSS_OFS_COUNT, 32'(cnt));
      wr(`SSS_OFS_DELAY, 32'h0000_01F4);
      sweep();
      `CHK(mgap >= 500, 1'b1)
      rd(`SSS_OFS_BURST_NUM);
      `CHK(d, 32'h0000_0004)
      rd(`SSS_OFS_BURST_INFO);
      `CHK(d[15:0], 16'((cnt + 3) / 4))
      `CHK(d[31:16], 16'(cnt + 4 - 4 * ((cnt + 3) / 4)))
      rd(`SSS_OFS_STATUS);
      `CHK(d[31:16], 16'(cnt))
      for (p = 0; p < cnt; p++) begin
         rd(`SSS_OFS_MEM_DATA);
         `CHK(d[15:0], slot(p, cnt))
      end
      cmd(sss_pkg::CMD_READ_COUNT);
      rd(`SSS_OFS_COUNT);
      `CHK(d, 32'(cnt))
      cmd(sss_pkg::CMD_MEM_FIFO);
      rd(`SSS_OFS_STATUS);
      `CHK(d[31:16], 16'h0000)
      $display("sweep test done");
      wr(`SSS_OFS_CONFIG, 32'h0000_0002);
      cmd(sss_pkg::CMD_SS_AC);
      `CHK(sn, 1'b1)
      `CHK(fmt, 2'h0)
      wr(`SSS_OFS_INTERVAL, 32'h0000_4E20);
      wr(`SSS_OFS_COUNT, 32'h0000_0002);
      sweep();
      `CHK(nsv, 2)
      `CHK(last_so, 16'h0007)
      $display("level test done");
      results();
   end
endmodule
